// ==== verilog/pio_regs.vh ====
// register map, field positions, reset values and timing counts of the parallel port block
// Summary of operation
// - three 8-bit bidirectional ports plus one 8-bit input-only port, per-bit direction.
// - a pin drives when its direction bit is one, is an input when zero.
// - any reset clears every direction register so all pins come up as inputs.
// - reset leaves the port output data latches unchanged.
// - direction registers read back the value last written.
// - data write with direction zero updates the latch only, pin stays undriven.
// - data write with direction one updates the latch and drives the pin one clock later.
// - data read with direction zero returns the synchronised pin level.
// - data read with direction one returns the output latch.
// - with wired-or enable set, high inputs on second port raise an interrupt request.
// - sense select 00 edge plus high, 01 rising, 10 falling, 11 both edges.
// - sense select bits writable only while cpu mask bit set; cleared by reset.
// - with pull-down option, second and third port input pins get pull-downs.
// - clock output on third port bit 2 forces its direction and latch readback.
// - clock output bit cleared by reset.
// - input-only port has no direction register, always readable, digital after reset.
// - converter on routes fourth port pins to the converter, off leaves them digital.
`ifndef PIO_REGS_VH
`define PIO_REGS_VH

// ----------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------
`define PIO_IDX_DATA_A    6'h00
`define PIO_IDX_DATA_B    6'h01
`define PIO_IDX_DATA_C    6'h02
`define PIO_IDX_DATA_D    6'h03
`define PIO_IDX_DIR_A     6'h04
`define PIO_IDX_DIR_B     6'h05
`define PIO_IDX_DIR_C     6'h06
`define PIO_IDX_NVMCLK    6'h07
`define PIO_IDX_ADCTL     6'h09
`define PIO_IDX_MISC      6'h0C
`define PIO_IDX_CTRL      6'h10

// ----------------------------------------
// byte addresses
// ----------------------------------------
`define PIO_ADDR_DATA_A   {`PIO_IDX_DATA_A, 2'b00}
`define PIO_ADDR_DATA_B   {`PIO_IDX_DATA_B, 2'b00}
`define PIO_ADDR_DATA_C   {`PIO_IDX_DATA_C, 2'b00}
`define PIO_ADDR_DATA_D   {`PIO_IDX_DATA_D, 2'b00}
`define PIO_ADDR_DIR_A    {`PIO_IDX_DIR_A, 2'b00}
`define PIO_ADDR_DIR_B    {`PIO_IDX_DIR_B, 2'b00}
`define PIO_ADDR_DIR_C    {`PIO_IDX_DIR_C, 2'b00}
`define PIO_ADDR_NVMCLK   {`PIO_IDX_NVMCLK, 2'b00}
`define PIO_ADDR_ADCTL    {`PIO_IDX_ADCTL, 2'b00}
`define PIO_ADDR_MISC     {`PIO_IDX_MISC, 2'b00}
`define PIO_ADDR_CTRL     {`PIO_IDX_CTRL, 2'b00}

// ----------------------------------------
// field positions
// ----------------------------------------
`define PIO_NVMCLK_CLKOUT 3
`define PIO_ADCTL_ADCON   5
`define PIO_MISC_POS      6
`define PIO_MISC_NEG      5
`define PIO_CTRL_WIRED_OR_INTERRUPT_ENABLE     0
`define PIO_CTRL_IMASK    1
`define PIO_CTRL_ACK      2
`define PIO_CLK_BIT       2

// ----------------------------------------
// reset values
// ----------------------------------------
`define PIO_DIR_RST       8'h00
`define PIO_NVMCLK_RST    8'h00
`define PIO_SENSE_RST     2'h0
`define PIO_LATCH_INIT    8'h00

// ----------------------------------------
// timing counts
// ----------------------------------------
`define PIO_SYNC_STAGES   2

`endif

// ==== verilog/pio_sync.v ====
// two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pio_sync #(
  parameter WIDTH = 8
) (
  // clock and reset
  input  wire             clk_sys_i,
  input  wire             resetn_i,
  // data
  input  wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule // pio_sync

// ==== verilog/pio_woi.v ====
// wired-or interrupt detector for the second port
`timescale 1ns/1ps
module pio_woi #(
  parameter WIDTH = 8
) (
  // clock and reset
  input  wire             clk_sys_i,
  input  wire             resetn_i,
  // control
  input  wire             enable_i,
  input  wire             pos_sel_i,
  input  wire             neg_sel_i,
  input  wire             ack_i,
  // pins
  input  wire [WIDTH-1:0] pins_i,
  input  wire [WIDTH-1:0] dir_i,
  // request
  output wire             req_o
);

  wire level;
  reg  level_q;
  reg  req_q;
  reg  req_d;
  wire rise;
  wire fall;

  // any high input pin forms one condition
  assign level = |(pins_i & ~dir_i);
  assign rise  = level & ~level_q;
  assign fall  = ~level & level_q;

  always @* begin
    req_d = req_q;
    if (ack_i)
      req_d = 1'b0;
    case ({pos_sel_i, neg_sel_i})
      2'b00:   if (rise | level) req_d = 1'b1;
      2'b01:   if (rise) req_d = 1'b1;
      2'b10:   if (fall) req_d = 1'b1;
      default: if (rise | fall) req_d = 1'b1;
    endcase
    if (!enable_i)
      req_d = 1'b0;
  end

  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      level_q <= 1'b0;
      req_q   <= 1'b0;
    end else begin
      level_q <= level;
      req_q   <= req_d;
    end
  end

  assign req_o = req_q;

endmodule // pio_woi

// ==== verilog/pio_top.v ====
// parallel io ports with axi4-lite register access
`timescale 1ns/1ps
`include "pio_regs.vh"
module pio_top (
  // clock and reset
  input  wire        clk_sys_i,
  input  wire        resetn_i,
  // axi4-lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // options
  input  wire        pulldown_opt_i,
  // bidirectional ports
  input  wire [7:0]  port_a_i,
  output reg  [7:0]  port_a_o,
  output reg  [7:0]  port_a_oe_o,
  input  wire [7:0]  port_b_i,
  output reg  [7:0]  port_b_o,
  output reg  [7:0]  port_b_oe_o,
  output reg  [7:0]  port_b_pd_o,
  input  wire [7:0]  port_c_i,
  output reg  [7:0]  port_c_o,
  output reg  [7:0]  port_c_oe_o,
  output reg  [7:0]  port_c_pd_o,
  // input-only port
  input  wire [7:0]  input_only_port_pins_i,
  output reg         analog_sel_o,
  // interrupt request
  output reg         wired_or_interrupt_o
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [7:0] latch_a_q;
  reg [7:0] latch_b_q;
  reg [7:0] latch_c_q;
  reg [7:0] dir_a_q;
  reg [7:0] dir_b_q;
  reg [7:0] dir_c_q;
  reg       clock_output_select_q;
  reg       converter_on_q;
  reg       positive_sense_select_q;
  reg       negative_sense_select_q;
  reg       wired_or_interrupt_enable_q;
  reg       irq_mask_q;
  reg       clk_div_q;
  reg [7:0] aw_addr_q;
  reg       aw_have_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg       w_have_q;
  reg       ack_pulse_q;

  wire [7:0] pin_a;
  wire [7:0] pin_b;
  wire [7:0] pin_c;
  wire [7:0] pin_d;
  wire       woi_req;
  wire [7:0] dir_c_eff;
  wire       do_write;
  wire       wr_lane0;
  reg  [7:0] rd_val;
  reg        rd_ok;
  reg        wr_ok;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  pio_sync #(.WIDTH(8)) u_sync_a (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .async_i   (port_a_i),
    .sync_o    (pin_a)
  );
  pio_sync #(.WIDTH(8)) u_sync_b (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .async_i   (port_b_i),
    .sync_o    (pin_b)
  );
  pio_sync #(.WIDTH(8)) u_sync_c (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .async_i   (port_c_i),
    .sync_o    (pin_c)
  );
  pio_sync #(.WIDTH(8)) u_sync_d (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .async_i   (input_only_port_pins_i),
    .sync_o    (pin_d)
  );

  // ----------------------------------------
  // wired-or interrupt
  // ----------------------------------------
  pio_woi #(.WIDTH(8)) u_woi (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .enable_i  (wired_or_interrupt_enable_q),
    .pos_sel_i (positive_sense_select_q),
    .neg_sel_i (negative_sense_select_q),
    .ack_i     (ack_pulse_q),
    .pins_i    (pin_b),
    .dir_i     (dir_b_q),
    .req_o     (woi_req)
  );

  // clock output forces third port bit 2 to output
  assign dir_c_eff = dir_c_q | ({7'h00, clock_output_select_q} << `PIO_CLK_BIT);

  // ----------------------------------------
  // axi write channel
  // ----------------------------------------
  assign do_write = aw_have_q & w_have_q & ~s_axi_bvalid;
  assign wr_lane0 = w_strb_q[0];

  always @* begin
    case (aw_addr_q)
      `PIO_ADDR_DATA_A, `PIO_ADDR_DATA_B, `PIO_ADDR_DATA_C, `PIO_ADDR_DATA_D,
      `PIO_ADDR_DIR_A, `PIO_ADDR_DIR_B, `PIO_ADDR_DIR_C, `PIO_ADDR_NVMCLK,
      `PIO_ADDR_ADCTL, `PIO_ADDR_MISC, `PIO_ADDR_CTRL: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h00000000;
      w_strb_q      <= 4'h0;
    end else begin
      s_axi_awready <= ~aw_have_q & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_have_q & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // port data latches, no reset
  // ----------------------------------------
  always @(posedge clk_sys_i) begin
    if (do_write & wr_lane0) begin
      if (aw_addr_q == `PIO_ADDR_DATA_A)
        latch_a_q <= w_data_q[7:0];
      if (aw_addr_q == `PIO_ADDR_DATA_B)
        latch_b_q <= w_data_q[7:0];
      if (aw_addr_q == `PIO_ADDR_DATA_C)
        latch_c_q <= w_data_q[7:0];
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dir_a_q                     <= `PIO_DIR_RST;
      dir_b_q                     <= `PIO_DIR_RST;
      dir_c_q                     <= `PIO_DIR_RST;
      clock_output_select_q       <= 1'b0;
      converter_on_q              <= 1'b0;
      positive_sense_select_q     <= 1'b0;
      negative_sense_select_q     <= 1'b0;
      wired_or_interrupt_enable_q <= 1'b0;
      irq_mask_q                  <= 1'b0;
      ack_pulse_q                 <= 1'b0;
    end else begin
      ack_pulse_q <= 1'b0;
      if (do_write & wr_lane0) begin
        case (aw_addr_q)
          `PIO_ADDR_DIR_A: dir_a_q <= w_data_q[7:0];
          `PIO_ADDR_DIR_B: dir_b_q <= w_data_q[7:0];
          `PIO_ADDR_DIR_C: dir_c_q <= w_data_q[7:0];
          `PIO_ADDR_NVMCLK: clock_output_select_q <= w_data_q[`PIO_NVMCLK_CLKOUT];
          `PIO_ADDR_ADCTL: converter_on_q <= w_data_q[`PIO_ADCTL_ADCON];
          `PIO_ADDR_MISC: begin
            if (irq_mask_q) begin
              positive_sense_select_q <= w_data_q[`PIO_MISC_POS];
              negative_sense_select_q <= w_data_q[`PIO_MISC_NEG];
            end
          end
          `PIO_ADDR_CTRL: begin
            wired_or_interrupt_enable_q <= w_data_q[`PIO_CTRL_WIRED_OR_INTERRUPT_ENABLE];
            irq_mask_q                  <= w_data_q[`PIO_CTRL_IMASK];
            ack_pulse_q                 <= w_data_q[`PIO_CTRL_ACK];
          end
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always @* begin
    rd_ok  = 1'b1;
    rd_val = 8'h00;
    case (s_axi_araddr)
      `PIO_ADDR_DATA_A: rd_val = (latch_a_q & dir_a_q) | (pin_a & ~dir_a_q);
      `PIO_ADDR_DATA_B: rd_val = (latch_b_q & dir_b_q) | (pin_b & ~dir_b_q);
      `PIO_ADDR_DATA_C: rd_val = (latch_c_q & dir_c_eff) | (pin_c & ~dir_c_eff);
      `PIO_ADDR_DATA_D: rd_val = converter_on_q ? 8'h00 : pin_d;
      `PIO_ADDR_DIR_A:  rd_val = dir_a_q;
      `PIO_ADDR_DIR_B:  rd_val = dir_b_q;
      `PIO_ADDR_DIR_C:  rd_val = dir_c_q;
      `PIO_ADDR_NVMCLK: rd_val = {4'h0, clock_output_select_q, 3'h0};
      `PIO_ADDR_ADCTL:  rd_val = {2'h0, converter_on_q, 5'h00};
      `PIO_ADDR_MISC:   rd_val = {1'b0, positive_sense_select_q, negative_sense_select_q, 5'h00};
      `PIO_ADDR_CTRL:   rd_val = {4'h0, woi_req, 1'b0, irq_mask_q, wired_or_interrupt_enable_q};
      default:          rd_ok  = 1'b0;
    endcase
  end

  // ----------------------------------------
  // axi read channel
  // ----------------------------------------
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rd_val};
        s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      clk_div_q            <= 1'b0;
      port_a_o             <= 8'h00;
      port_a_oe_o          <= 8'h00;
      port_b_o             <= 8'h00;
      port_b_oe_o          <= 8'h00;
      port_b_pd_o          <= 8'h00;
      port_c_o             <= 8'h00;
      port_c_oe_o          <= 8'h00;
      port_c_pd_o          <= 8'h00;
      analog_sel_o         <= 1'b0;
      wired_or_interrupt_o <= 1'b0;
    end else begin
      clk_div_q            <= ~clk_div_q;
      port_a_o             <= latch_a_q;
      port_a_oe_o          <= dir_a_q;
      port_b_o             <= latch_b_q;
      port_b_oe_o          <= dir_b_q;
      port_b_pd_o          <= pulldown_opt_i ? ~dir_b_q : 8'h00;
      port_c_o             <= clock_output_select_q ?
                              ((latch_c_q & ~(8'h01 << `PIO_CLK_BIT)) | ({7'h00, clk_div_q} << `PIO_CLK_BIT))
                              : latch_c_q;
      port_c_oe_o          <= dir_c_eff;
      port_c_pd_o          <= pulldown_opt_i ? ~dir_c_eff : 8'h00;
      analog_sel_o         <= converter_on_q;
      wired_or_interrupt_o <= woi_req;
    end
  end

endmodule // pio_top

// ==== test/pio_board.sv ====
// board model for the pins of one bidirectional port
`timescale 1ns/1ps
module pio_board (
  // clock
  input  wire        clk_sys_i,
  // device side
  input  wire  [7:0] drv_i,
  input  wire  [7:0] oe_i,
  input  wire  [7:0] pd_i,
  // board side
  input  wire  [7:0] ext_i,
  input  wire  [7:0] ext_en_i,
  output logic [7:0] pin_o
);
  logic [7:0] flt_q = 8'h00;
  // a floating pin without pull-down shows noise, never a held value
  always @(posedge clk_sys_i) begin
    flt_q <= ~flt_q;
  end
  assign pin_o = (oe_i & drv_i) | (~oe_i & ext_en_i & ext_i) | (~oe_i & ~ext_en_i & ~pd_i & flt_q);
endmodule // pio_board

// ==== test/pio_assertions.sv ====
// checker for the parallel io port block
`timescale 1ns/1ps
module pio_assertions (
  // clock and reset
  input wire        clk_sys_i,
  input wire        resetn_i,
  // bus
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_bvalid,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [7:0]  s_axi_araddr,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  // pins
  input wire        pulldown_opt_i,
  input wire [7:0]  port_a_i,
  input wire [7:0]  port_a_o,
  input wire [7:0]  port_a_oe_o,
  input wire [7:0]  port_b_oe_o,
  input wire [7:0]  port_b_pd_o,
  input wire [7:0]  port_c_oe_o,
  input wire        analog_sel_o,
  input wire        wired_or_interrupt_o
);
  logic [7:0] raddr_q;
  logic       rd_done;
  assign rd_done = s_axi_rvalid && s_axi_rready;
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      raddr_q <= 8'h00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      raddr_q <= s_axi_araddr;
    end
  end
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!resetn_i);
  chk_rst_dir: assert property ($rose(resetn_i) |-> (port_a_oe_o | port_b_oe_o | port_c_oe_o) == 8'h00)
    else $error("drive enable set after reset");
  chk_pd_b: assert property ($past(resetn_i) |-> port_b_pd_o == ($past(pulldown_opt_i) ? ~port_b_oe_o : 8'h00))
    else $error("pull-down b wrong");
  chk_rd_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_wr_resp: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid)
    else $error("write answer late");
  chk_a_latch: assert property (rd_done && raddr_q == 8'h00 |-> ((s_axi_rdata[7:0] ^ port_a_o) & port_a_oe_o) == 8'h00)
    else $error("output bit read not latch");
  chk_a_pin: assert property (rd_done && raddr_q == 8'h00 |->
    ((s_axi_rdata[7:0] ^ $past(port_a_i, 3)) & ~port_a_oe_o) == 8'h00)
    else $error("input bit read not pin");
  chk_d_adc: assert property (rd_done && raddr_q == 8'h0C && analog_sel_o |-> s_axi_rdata == 32'h00000000)
    else $error("port d digital while converter on");
  chk_hi_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  cov_adc_read: cover property (rd_done && raddr_q == 8'h0C && analog_sel_o);
  cov_irq: cover property ($rose(wired_or_interrupt_o));
  cov_pd: cover property (port_b_pd_o != 8'h00);
endmodule // pio_assertions
bind pio_top pio_assertions u_chk (.clk_sys_i, .resetn_i, .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .pulldown_opt_i,
  .port_a_i, .port_a_o, .port_a_oe_o, .port_b_oe_o, .port_b_pd_o, .port_c_oe_o, .analog_sel_o, .wired_or_interrupt_o);

// ==== test/testbench.sv ====
// self-checking bench for the parallel io port block
`timescale 1ns/1ps
module testbench;
  logic        clk_sys_i, resetn_i, pulldown_opt_i;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, ext_a, ext_b, ext_c, b_en, port_d, v, v2, d, lat;
  logic [31:0] s_axi_wdata, rd, rnd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  rr;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, analog_sel_o, irq;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [7:0]  pa_o, pa_oe, pa, pb_o, pb_oe, pb_pd, pb, pc_o, pc_oe, pc_pd, pc;
  int          err_count, samples_checked, seed;
  localparam logic [39:0] rst_addrs = 40'h1014181C24;
  pio_top uut (.clk_sys_i, .resetn_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pulldown_opt_i, .port_a_i(pa),
    .port_a_o(pa_o), .port_a_oe_o(pa_oe), .port_b_i(pb), .port_b_o(pb_o), .port_b_oe_o(pb_oe), .port_b_pd_o(pb_pd),
    .port_c_i(pc), .port_c_o(pc_o), .port_c_oe_o(pc_oe), .port_c_pd_o(pc_pd), .input_only_port_pins_i(port_d),
    .analog_sel_o, .wired_or_interrupt_o(irq));
  pio_board brd_a (.clk_sys_i, .drv_i(pa_o), .oe_i(pa_oe), .pd_i(8'h00), .ext_i(ext_a), .ext_en_i(8'hFF), .pin_o(pa));
  pio_board brd_b (.clk_sys_i, .drv_i(pb_o), .oe_i(pb_oe), .pd_i(pb_pd), .ext_i(ext_b), .ext_en_i(b_en), .pin_o(pb));
  pio_board brd_c (.clk_sys_i, .drv_i(pc_o), .oe_i(pc_oe), .pd_i(pc_pd), .ext_i(ext_c), .ext_en_i(8'hFF), .pin_o(pc));
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  // ----
  // tasks
  // ----
  task automatic cmp(input logic [7:0] g, input logic [7:0] e, input string m);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] x, input logic [3:0] s = 4'hF);
    @(posedge clk_sys_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, x};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge clk_sys_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic chkrd(input logic [7:0] a, input logic [7:0] e, input string m);
    rdr(a);
    cmp(rd[7:0], e, m);
  endtask
  task automatic do_reset();
    resetn_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
  endtask
  function automatic logic [7:0] exp_rd(input logic [7:0] l, input logic [7:0] dr, input logic [7:0] p);
    return (l & dr) | (p & ~dr);
  endfunction
  function automatic logic exp_irq(input int m, input logic rise);
    return rise ? (m != 2) : (m != 1);
  endfunction
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6000) @(posedge clk_sys_i);
    err_count++;
    results();
  end
  // ----
  // scenarios
  // ----
  initial begin
    seed = 7;
    err_count = 0;
    samples_checked = 0;
    pulldown_opt_i = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, ext_a, ext_b, ext_c, port_d} = 48'h000000000000;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hF;
    b_en = 8'hFF;
    do_reset();
    cmp(pa_oe | pb_oe | pc_oe, 8'h00, "oe after reset");
    for (int i = 4; i >= 0; i--) chkrd(rst_addrs[i*8 +: 8], 8'h00, "reset");
    $display("test reset values done");
    for (int i = 0; i < 24; i++) begin
      rnd = $random(seed);
      {v2, lat, d, v} = rnd;
      ext_c <= lat;
      if (i == 0) d = 8'hFF;
      if (i == 1) d = 8'h00;
      rnd = $random(seed);
      ext_a <= rnd[7:0];
      ext_b <= rnd[15:8];
      b_en <= rnd[23:16];
      port_d <= rnd[31:24];
      pulldown_opt_i <= rnd[0] ^ rnd[9];
      wr(8'h00, v);
      wr(8'h08, v);
      wr(8'h10, d);
      wr(8'h18, d);
      wr(8'h14, d);
      wr(8'h00, v2);
      repeat (6) @(posedge clk_sys_i);
      cmp(pa_oe, d, "a oe");
      cmp(pa_o & d, v2 & d, "a out");
      cmp(pb_pd, pulldown_opt_i ? ~d : 8'h00, "b pd");
      cmp(pc_pd, pulldown_opt_i ? ~d : 8'h00, "c pd");
      chkrd(8'h00, exp_rd(v2, d, ext_a), "a read");
      chkrd(8'h08, exp_rd(v, d, ext_c), "c read");
      chkrd(8'h10, d, "dir a");
      chkrd(8'h0C, port_d, "d read");
    end
    $display("test random port traffic done");
    do_reset();
    {ext_b, b_en} <= 16'h00FF;
    wr(8'h10, 8'hFF);
    repeat (2) @(posedge clk_sys_i);
    cmp(pa_o, v2, "latch kept");
    wr(8'h30, 8'h60);
    rdr(8'h30);
    cmp(rd[7:0] & 8'h60, 8'h00, "sense locked");
    wr(8'h40, 8'h02);
    wr(8'h30, 8'h60);
    rdr(8'h30);
    cmp(rd[7:0] & 8'h60, 8'h60, "sense open");
    $display("test reset and sense lock done");
    for (int m = 0; m < 4; m++) begin
      wr(8'h30, {1'b0, m[1:0], 5'h00});
      wr(8'h40, 8'h07);
      ext_b <= 8'h10;
      repeat (6) @(posedge clk_sys_i);
      cmp({7'h00, irq}, {7'h00, exp_irq(m, 1'b1)}, "irq rise");
      wr(8'h40, 8'h07);
      repeat (2) @(posedge clk_sys_i);
      cmp({7'h00, irq}, {7'h00, m == 0}, "irq ack");
      ext_b <= 8'h00;
      repeat (6) @(posedge clk_sys_i);
      cmp({7'h00, irq}, {7'h00, exp_irq(m, 1'b0)}, "irq fall");
    end
    wr(8'h30, 8'h00);
    wr(8'h04, 8'hFF);
    wr(8'h14, 8'hFF);
    wr(8'h40, 8'h07);
    repeat (6) @(posedge clk_sys_i);
    cmp({7'h00, irq}, 8'h00, "irq output pins");
    cmp(pb_o & pb_oe, 8'hFF, "b out");
    wr(8'h14, 8'h00);
    ext_b <= 8'h01;
    wr(8'h40, 8'h02);
    repeat (6) @(posedge clk_sys_i);
    cmp({7'h00, irq}, 8'h00, "irq disabled");
    $display("test wired-or interrupt done");
    ext_c <= 8'h00;
    wr(8'h08, 8'h04);
    wr(8'h1C, 8'h08);
    repeat (2) @(posedge clk_sys_i);
    cmp(pc_oe, 8'h04, "clk out oe");
    lat = pc_o;
    @(posedge clk_sys_i);
    cmp({7'h00, pc_o[2]}, {7'h00, ~lat[2]}, "clk toggles");
    chkrd(8'h08, 8'h04, "clk bit reads latch");
    do_reset();
    cmp(pc_oe, 8'h00, "clk out off");
    chkrd(8'h1C, 8'h00, "clk bit reset");
    $display("test clock output done");
    wr(8'h24, 8'h20);
    repeat (2) @(posedge clk_sys_i);
    cmp({7'h00, analog_sel_o}, 8'h01, "converter on");
    chkrd(8'h0C, 8'h00, "d analog");
    wr(8'h24, 8'h00);
    chkrd(8'h0C, port_d, "d digital");
    wr(8'h50, 8'h12);
    cmp({6'h00, rr}, 8'h02, "unmapped write");
    rdr(8'h50);
    cmp({6'h00, rr}, 8'h02, "unmapped read");
    wr(8'h10, 8'hFF, 4'h0);
    chkrd(8'h10, 8'h00, "no strobe");
    $display("test converter and refusals done");
    results();
  end
endmodule // testbench
